// file: pkg/ov_resp_pkg.sv
/*
 * Shared constants and types for the output-voltage format, turn-on
 * threshold and over-voltage fault response block.
 * Assumes a 100 MHz core clock and an upstream bus engine that hands over
 * whole decoded commands.
 */
package ov_resp_pkg;

   // command codes
   localparam logic [7:0] CMD_FAULT_FLAG_CLEAR = 8'h03;
   localparam logic [7:0] CMD_OUT_FORMAT       = 8'h20;
   localparam logic [7:0] CMD_TURN_ON_THRESH   = 8'h35;
   localparam logic [7:0] CMD_OV_LIMIT         = 8'h40;
   localparam logic [7:0] CMD_OV_ACTION        = 8'h41;

   typedef enum logic [2:0] {
      VMODE_LINEAR = 3'h0,
      VMODE_VID    = 3'h1,
      VMODE_DIRECT = 3'h2
   } vmode_e;

   typedef enum logic [1:0] {
      RESP_IGNORE  = 2'h0,
      RESP_DISABLE = 2'h2
   } resp_e;

   localparam logic [2:0] RETRY_NONE    = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;
   localparam logic [4:0] PARAM_ZERO    = 5'h00;

   typedef struct packed {
      logic [2:0] mode;
      logic [4:0] param;
   } format_s;

   typedef struct packed {
      logic [1:0] response;
      logic [2:0] retries;
      logic [2:0] delay;
   } action_s;

   // reset values
   localparam format_s     FORMAT_RST         = 8'h1B;
   localparam logic [15:0] TURN_ON_THRESH_RST = 16'h0000;
   localparam logic [15:0] OV_LIMIT_RST       = 16'hFFFF;
   localparam action_s     ACTION_RST         = 8'h80;

   // retry delay unit
   localparam int unsigned RETRY_UNIT_MS     = 200;
   localparam int unsigned CLK_PERIOD_NS     = 10;
   localparam int unsigned RETRY_UNIT_CYCLES = RETRY_UNIT_MS * 1000000 / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ST_OFF        = 2'b00,
      ST_RUN        = 2'b01,
      ST_RETRY_WAIT = 2'b11,
      ST_LATCHED    = 2'b10
   } conv_e;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  code;
      logic [15:0] wdata;
   } cmd_req_s;

   typedef struct packed {
      logic        ack;
      logic        err;
      logic [15:0] rdata;
   } cmd_rsp_s;

   typedef struct packed {
      logic [31:0] cnt;
      logic        busy;
      logic        done;
   } timer_s;

endpackage : ov_resp_pkg

// file: logic/retry_timer.sv
/*
 * Down-counting one-shot timer for the restart interval.
 * Assumes the caller reloads it for each interval and ignores done elsewhere.
 */
`timescale 1ns/1ps
module retry_timer
   import ov_resp_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        load,
   input  wire logic [31:0] load_cycles,
   output      logic        done
);
   timer_s s;
   timer_s next_s;

   always_comb begin
      next_s      = s;
      next_s.done = 1'b0;
      if (load) begin
         // zero delay still costs one cycle so the restart is a real edge
         next_s.cnt  = (load_cycles == 32'h0) ? 32'h1 : load_cycles;
         next_s.busy = 1'b1;
      end else if (s.busy) begin
         if (s.cnt == 32'h1) begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
         end else begin
            next_s.cnt = s.cnt - 32'h1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign done = s.done;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   AST_TMR_DONE: assert property (s.busy && s.cnt == 32'h1 && !load |=> done) // R13
      else $error("timer did not expire on its last count");

endmodule : retry_timer

// file: logic/ov_fault_ctrl.sv
/*
 * Command registers for output-voltage format, input turn-on threshold,
 * over-voltage limit and over-voltage response, plus the shutdown and
 * retry state machine.
 * Assumes an upstream bus engine presents one decoded command per valid
 * cycle, and that measurements arrive already scaled to the register codes.
 */
`timescale 1ns/1ps
// Overview of operation
// R1: linear mode: low five bits are exponent
// R2: top three bits pick linear, VID, direct
// R3: direct mode keeps parameter field zero
// R4: conversion starts once input reaches threshold
// R5: host codes threshold with exponent minus three
// R6: store unsigned over-voltage limit, exponent minus five
// R7: low three action bits: delay, 200 ms steps
// R8: response 00 keeps output running on fault
// R9: response 10 disables, then follows retry count
// R10: retry count zero latches output off
// R11: counts one to six limit restarts, then latch
// R12: count seven retries until commanded off
// R13: restart interval is delay times unit
// R14: fault clear command clears flags, releases latch
// R15: output above limit declares over-voltage fault
module ov_fault_ctrl
   import ov_resp_pkg::*;
#(
   parameter int unsigned RETRY_UNIT_CYCLES_P = RETRY_UNIT_CYCLES
)(
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire cmd_req_s    cmd_req,
   output      cmd_rsp_s    cmd_rsp,
   input  wire logic [15:0] vin_meas,
   input  wire logic [15:0] vout_meas,
   input  wire logic        run_request,
   input  wire logic        bias_ok,
   input  wire logic        other_fault,
   output      logic        power_enable,
   output      logic        ov_fault_flag,
   output      logic        output_latched_off,
   output      vmode_e      vout_data_mode,
   output      logic [4:0]  vout_exponent
);

   typedef struct packed {
      format_s     fmt;
      logic [15:0] turn_on_thresh;
      logic [15:0] ov_limit;
      action_s     act;
      conv_e       st;
      logic [2:0]  attempts;
      logic        ov_flag;
      cmd_rsp_s    rsp;
   } state_s;

   state_s      s;
   state_s      next_s;
   logic        ov_now;
   logic        clear;
   logic        enable_ok;
   logic        tmr_load;
   logic        tmr_done;
   logic [31:0] tmr_cycles;
   logic        shutdown_on_ov;
   logic        retries_spent;

   assign ov_now    = vout_meas > s.ov_limit; // R15
   assign clear     = cmd_req.valid && cmd_req.write && cmd_req.code == CMD_FAULT_FLAG_CLEAR;
   // loss of command, bias or another fault stops any retry sequence
   assign enable_ok = run_request && bias_ok && !other_fault; // R12
   assign shutdown_on_ov = s.act.response[1];
   assign retries_spent  = s.act.retries != RETRY_FOREVER && s.attempts == s.act.retries;
   assign tmr_cycles = 32'(s.act.delay * RETRY_UNIT_CYCLES_P); // R7 R13

   always_comb begin
      next_s   = s;
      next_s.rsp = '0;
      tmr_load = 1'b0;

      if (cmd_req.valid) begin
         next_s.rsp.ack = 1'b1;
         case (cmd_req.code)
            CMD_FAULT_FLAG_CLEAR: begin
               next_s.rsp.err = !cmd_req.write;
            end
            CMD_OUT_FORMAT: begin
               if (cmd_req.write) begin
                  next_s.fmt = cmd_req.wdata[7:0]; // R1 R2
                  if (next_s.fmt.mode == VMODE_DIRECT) begin
                     next_s.fmt.param = PARAM_ZERO; // R3
                  end
               end
               next_s.rsp.rdata = {8'h00, s.fmt};
            end
            CMD_TURN_ON_THRESH: begin
               if (cmd_req.write) begin
                  next_s.turn_on_thresh = cmd_req.wdata; // R4
               end
               next_s.rsp.rdata = s.turn_on_thresh;
            end
            CMD_OV_LIMIT: begin
               if (cmd_req.write) begin
                  next_s.ov_limit = cmd_req.wdata; // R6
               end
               next_s.rsp.rdata = s.ov_limit;
            end
            CMD_OV_ACTION: begin
               if (cmd_req.write) begin
                  next_s.act = cmd_req.wdata[7:0];
               end
               next_s.rsp.rdata = {8'h00, s.act};
            end
            default: begin
               next_s.rsp.err = 1'b1;
            end
         endcase
      end

      // a fault in the same cycle as the clear survives
      next_s.ov_flag = (s.ov_flag && !clear) || ov_now; // R14 R15
      if (clear) begin
         next_s.attempts = '0;
      end

      case (s.st)
         ST_OFF: begin
            next_s.attempts = '0;
            if (enable_ok && vin_meas >= s.turn_on_thresh) begin // R4
               next_s.st = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!enable_ok) begin
               next_s.st = ST_OFF;
            end else if (ov_now && shutdown_on_ov) begin // R8 R9
               if (s.act.retries == RETRY_NONE || retries_spent) begin // R10 R11
                  next_s.st = ST_LATCHED;
               end else begin
                  next_s.st = ST_RETRY_WAIT;
                  tmr_load  = 1'b1; // R13
               end
            end
         end
         ST_RETRY_WAIT: begin
            if (!enable_ok) begin
               next_s.st = ST_OFF; // R12
            end else if (tmr_done) begin
               next_s.st = ST_RUN;
               // counter is not advanced for endless retry, so it never wraps
               if (s.act.retries != RETRY_FOREVER) begin // R11 R12
                  next_s.attempts = s.attempts + 3'h1;
               end
            end
         end
         ST_LATCHED: begin
            if (clear) begin
               next_s.st = ST_OFF; // R14
            end
         end
         default: begin
            next_s.st = ST_OFF;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s.fmt      <= FORMAT_RST;
         s.turn_on_thresh <= TURN_ON_THRESH_RST;
         s.ov_limit <= OV_LIMIT_RST;
         s.act      <= ACTION_RST;
         s.st       <= ST_OFF;
         s.attempts <= '0;
         s.ov_flag  <= 1'b0;
         s.rsp      <= '0;
      end else begin
         s <= next_s;
      end
   end

   retry_timer retry_timer_i (
      .ref_clk     (ref_clk),
      .rstn        (rstn),
      .load        (tmr_load),
      .load_cycles (tmr_cycles),
      .done        (tmr_done)
   );

   assign cmd_rsp            = s.rsp;
   assign power_enable       = s.st == ST_RUN;
   assign ov_fault_flag      = s.ov_flag;
   assign output_latched_off = s.st == ST_LATCHED;
   assign vout_data_mode     = vmode_e'(s.fmt.mode);
   assign vout_exponent      = s.fmt.param;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   AST_FMT_EXP: assert property (cmd_req.valid && cmd_req.write && cmd_req.code == CMD_OUT_FORMAT
         && cmd_req.wdata[7:5] == VMODE_LINEAR |=> vout_exponent == $past(cmd_req.wdata[4:0])) // R1
      else $error("linear exponent not taken from format write");
   AST_FMT_MODE: assert property (cmd_req.valid && cmd_req.write && cmd_req.code == CMD_OUT_FORMAT
         |=> vout_data_mode == $past(cmd_req.wdata[7:5])) // R2
      else $error("data mode not taken from format write");
   AST_DIRECT_ZERO: assert property (vout_data_mode == VMODE_DIRECT |-> vout_exponent == PARAM_ZERO) // R3
      else $error("direct mode with nonzero parameter");
   AST_VIN_GATE: assert property ($rose(power_enable) && $past(s.st) == ST_OFF
         |-> $past(vin_meas) >= $past(s.turn_on_thresh)) // R4
      else $error("started below input threshold");
   AST_IGNORE: assert property (power_enable && ov_now && s.act.response == RESP_IGNORE
         && enable_ok |=> power_enable) // R8
      else $error("ignored fault disabled the output");
   AST_DISABLE: assert property (power_enable && ov_now && shutdown_on_ov |=> !power_enable) // R9
      else $error("over-voltage did not disable output");
   AST_LATCH_HOLD: assert property (output_latched_off && !clear |=> output_latched_off && !power_enable) // R10
      else $error("latched output left without clear");
   AST_RETRY_LIMIT: assert property (power_enable && enable_ok && ov_now && shutdown_on_ov
         && (s.act.retries == RETRY_NONE || retries_spent) |=> output_latched_off) // R11
      else $error("retry limit did not latch output off");
   AST_FOREVER: assert property (power_enable && enable_ok && ov_now && shutdown_on_ov
         && s.act.retries == RETRY_FOREVER |=> s.st == ST_RETRY_WAIT) // R12
      else $error("endless retry latched off");
   AST_CLEAR: assert property (clear && !ov_now |=> !ov_fault_flag) // R14
      else $error("clear did not drop fault flag");
   AST_OV_SET: assert property (ov_now |=> ov_fault_flag) // R15
      else $error("over-voltage not flagged");

   COV_IGNORE_RUN: cover property (power_enable && ov_now && s.act.response == RESP_IGNORE ##1 power_enable);
   COV_RETRY_RESTART: cover property (s.st == ST_RETRY_WAIT ##1 power_enable);
   COV_LATCH_CLEAR: cover property (output_latched_off ##1 clear ##1 s.st == ST_OFF);

endmodule : ov_fault_ctrl

// file: verification/cmd_host.sv
/*
 * Host-side command model for the over-voltage response block.
 * Assumes the caller enters xfer at a falling edge of ref_clk.
 */
`timescale 1ns/1ps
module cmd_host
   import ov_resp_pkg::*;
(
   input  wire logic     ref_clk,
   output      cmd_req_s cmd_req,
   input  wire cmd_rsp_s cmd_rsp
);
   initial cmd_req = '{valid: 1'b0, write: 1'b0, code: 8'hFF, wdata: 16'hFFFF};

   function automatic logic [15:0] lin_m3(input logic [10:0] mant);
      return {5'h1D, mant};
   endfunction : lin_m3

   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                       output cmd_rsp_s rsp, output logic ok);
      cmd_req = '{valid: 1'b1, write: w, code: c, wdata: d};
      @(negedge ref_clk);
      // released fields flip so a stale value can never look valid
      cmd_req = '{valid: 1'b0, write: ~w, code: ~c, wdata: ~d};
      ok = 1'b0;
      rsp = '0;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (cmd_rsp.ack === 1'b1) begin
            ok = 1'b1;
            rsp = cmd_rsp;
         end
         else @(negedge ref_clk);
      end
      // idle cycle keeps the next call from re-raising valid in this step
      @(negedge ref_clk);
   endtask : xfer
endmodule : cmd_host

// file: verification/ov_fault_ctrl_bench.sv
/*
 * Self-checking bench for the over-voltage response block.
 * Assumes a shortened retry unit of 4 cycles and the cmd_host model.
 */
`timescale 1ns/1ps
module ov_fault_ctrl_bench
   import ov_resp_pkg::*;
;
   logic        ref_clk = 1'b0;
   logic        rstn = 1'b0;
   logic [15:0] vin_meas = 16'h0000;
   logic [15:0] vout_meas = 16'h0000;
   logic        run_request = 1'b0;
   logic        bias_ok = 1'b1;
   logic        other_fault = 1'b0;
   cmd_req_s    cmd_req;
   cmd_rsp_s    cmd_rsp;
   cmd_rsp_s    r;
   logic        power_enable;
   logic        ov_fault_flag;
   logic        output_latched_off;
   vmode_e      vout_data_mode;
   logic [4:0]  vout_exponent;
   int          errors = 0;
   int          checks = 0;
   int          rises;
   int          gap;

   always #5 ref_clk = ~ref_clk;

   ov_fault_ctrl #(.RETRY_UNIT_CYCLES_P(4)) ov_fault_ctrl_i (
      .ref_clk(ref_clk), .rstn(rstn), .cmd_req(cmd_req), .cmd_rsp(cmd_rsp),
      .vin_meas(vin_meas), .vout_meas(vout_meas), .run_request(run_request),
      .bias_ok(bias_ok), .other_fault(other_fault), .power_enable(power_enable),
      .ov_fault_flag(ov_fault_flag), .output_latched_off(output_latched_off),
      .vout_data_mode(vout_data_mode), .vout_exponent(vout_exponent));

   cmd_host cmd_host_i (.ref_clk(ref_clk), .cmd_req(cmd_req), .cmd_rsp(cmd_rsp));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic results;
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results

   task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
      logic ok;
      cmd_host_i.xfer(w, c, d, r, ok);
      if (!ok) begin
         errors++;
         results();
      end
   endtask : cmd

   task automatic rd(input logic [7:0] c, input logic [15:0] exp);
      cmd(1'b0, c, 16'h0000);
      chk({r.err, r.rdata}, {1'b0, exp});
   endtask : rd

   // counts rises of the output enable and the low run before the last one
   task automatic watch(input int n);
      int low;
      rises = 0;
      gap = 0;
      low = 0;
      repeat (n) begin
         @(negedge ref_clk);
         if (power_enable === 1'b1 && low > 0) begin
            rises++;
            gap = low;
         end
         low = (power_enable === 1'b1) ? 0 : low + 1;
      end
   endtask : watch

   initial begin
      int d;
      repeat (20) @(negedge ref_clk);
      rstn = 1'b1;
      @(negedge ref_clk);
      rd(CMD_OUT_FORMAT, 16'h001B);
      rd(CMD_TURN_ON_THRESH, 16'h0000);
      rd(CMD_OV_LIMIT, 16'hFFFF);
      rd(CMD_OV_ACTION, 16'h0080);
      chk({vout_data_mode, vout_exponent}, 8'h1B);
      for (int m = 0; m < 3; m++) begin
         cmd(1'b1, CMD_OUT_FORMAT, {8'h00, m[2:0], 5'h15});
         chk({vout_data_mode, vout_exponent}, {m[2:0], (m == 2) ? 5'h00 : 5'h15});
      end
      rd(CMD_OUT_FORMAT, 16'h0040);
      cmd(1'b0, CMD_FAULT_FLAG_CLEAR, 16'h0000);
      chk(r.err, 1'b1);
      // input below threshold must keep conversion off
      vin_meas = cmd_host_i.lin_m3(11'h0FF);
      cmd(1'b1, CMD_TURN_ON_THRESH, cmd_host_i.lin_m3(11'h100));
      run_request = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk(power_enable, 1'b0);
      vin_meas = cmd_host_i.lin_m3(11'h100);
      repeat (2) @(negedge ref_clk);
      chk(power_enable, 1'b1);
      cmd(1'b1, CMD_OV_LIMIT, 16'h1000);
      chk(r.rdata, 16'hFFFF);
      cmd(1'b1, CMD_OV_ACTION, 16'h0000);
      vout_meas = 16'h1000;
      watch(4);
      chk(ov_fault_flag, 1'b0);
      vout_meas = 16'h1001;
      watch(6);
      chk({ov_fault_flag, power_enable, rises[0]}, 3'b110);
      vout_meas = 16'h0000;
      cmd(1'b1, CMD_FAULT_FLAG_CLEAR, 16'h0000);
      chk(ov_fault_flag, 1'b0);
      cmd(1'b1, CMD_OV_ACTION, 16'h0080);
      vout_meas = 16'h1001;
      watch(20);
      vout_meas = 16'h0000;
      watch(5);
      chk({output_latched_off, power_enable, rises[0]}, 3'b100);
      cmd(1'b1, CMD_FAULT_FLAG_CLEAR, 16'h0000);
      watch(4);
      chk({output_latched_off, power_enable}, 2'b01);
      for (int n = 1; n < 8; n++) begin
         d = (n == 7) ? 1 : n;
         cmd(1'b1, CMD_OV_ACTION, {8'h00, 2'b10, n[2:0], d[2:0]});
         vout_meas = 16'h1001;
         watch(200);
         chk(gap, d * 4 + 1);
         chk(output_latched_off, n != 7);
         chk((n == 7) ? (rises > 6) : (rises == n), 1'b1);
         if (n == 7) begin
            // each stop cause in turn: command off, bias loss, other fault
            for (int k = 0; k < 3; k++) begin
               run_request = (k != 0);
               bias_ok     = (k != 1);
               other_fault = (k == 2);
               watch(12);
               chk({power_enable, output_latched_off, rises[3:0]}, 6'h00);
               run_request = 1'b1;
               bias_ok     = 1'b1;
               other_fault = 1'b0;
               if (k < 2) begin
                  watch(12);
                  chk(rises > 0, 1'b1);
               end
            end
         end
         vout_meas = 16'h0000;
         cmd(1'b1, CMD_FAULT_FLAG_CLEAR, 16'h0000);
         watch(3);
         chk(power_enable, 1'b1);
      end
      results();
   end
endmodule : ov_fault_ctrl_bench
